// File: mdcc_pkg.sv
// Package: register map, field layout and reset values of the code path
package mdcc_pkg;

  // Channel count and code width
  localparam int NUM_CHANNELS = 40;
  localparam int CODE_W       = 12;
  localparam int CHAN_IDX_W   = 6;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] WRITE_OFFSET    = 12'h004;
  localparam logic [11:0] LOAD_OFFSET     = 12'h008;
  localparam logic [11:0] SFR_OFFSET      = 12'h00C;
  localparam logic [11:0] RDSEL_OFFSET    = 12'h010;
  localparam logic [11:0] RDINPUT_OFFSET  = 12'h014;
  localparam logic [11:0] RDOFFSET_OFFSET = 12'h018;
  localparam logic [11:0] RDGAIN_OFFSET   = 12'h01C;
  localparam logic [11:0] RDCODE_OFFSET   = 12'h020;

  // Control register fields
  localparam int REF_SOURCE_POS = 0;
  localparam int REF_LEVEL_POS  = 1;

  // Routed write word fields
  localparam int DATA_LSB       = 0;
  localparam int DATA_MSB       = 11;
  localparam int SEL_LOW_POS    = 12;
  localparam int SEL_HIGH_POS   = 13;
  localparam int CHAN_LSB       = 16;
  localparam int CHAN_MSB       = 21;

  // Register select codes, high bit then low bit
  localparam logic [1:0] SEL_INPUT  = 2'h3;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_GAIN   = 2'h1;
  localparam logic [1:0] SEL_SFR    = 2'h0;

  // Reset values
  localparam logic [11:0] GAIN_RESET   = 12'hFFE;
  localparam logic [11:0] OFFSET_RESET = 12'h800;
  localparam logic [11:0] INPUT_RESET  = 12'h000;
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic        REF_SOURCE_RESET = 1'b0;
  localparam logic        REF_LEVEL_RESET  = 1'b0;

  // Transfer function constants
  localparam logic [12:0] GAIN_BIAS   = 13'h0002;
  localparam logic [14:0] OFFSET_MID  = 15'h0800;
  localparam logic [11:0] CODE_MAX    = 12'hFFF;

endpackage

// File: mdcc_channel_core.sv
// Module: APB-reached 40-channel code path with gain/offset correction
//
// Summary of operation
// - Forty channels, each a 12-bit unsigned code
// - Source bit picks reference, level bit picks magnitude
// - Code equals scaled input plus offset minus midscale
// - Gain resets to FFE, bit zero forced low
// - Offset resets to 800, meaning no correction
// - Writes hit input stage; load strobe updates all
// - Select bits route word to input/offset/gain/special
// - Input code is straight binary output level
// - Offset is offset binary, 800 means zero
// - Gain scales linearly, FFE means unity gain
// - Every channel owns private gain and offset
// - Source bit one internal, zero external default
module mdcc_channel_core #(
  parameter int NUM_CH = mdcc_pkg::NUM_CHANNELS,
  parameter int DATA_W = mdcc_pkg::CODE_W
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  // APB slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [11:0]              paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // Load strobe pin, active low
  input  wire logic                     load_outputs_strobe_n_i,
  // Reference control
  output logic                          reference_source_o,
  output logic                          reference_level_o,
  // Converter codes, channel 0 in the low bits
  output logic      [NUM_CH*DATA_W-1:0] dac_code_o
);

  // Channel index in range
  function automatic logic chan_ok(input logic [5:0] idx);
    chan_ok = ({26'h0000000, idx} < NUM_CH);
  endfunction

  // Read word for an address
  function automatic logic [31:0] rd_word(
    input logic [11:0]       addr,
    input logic [31:0]       ctrl,
    input logic [11:0]       sfr,
    input logic [5:0]        sel,
    input logic [DATA_W-1:0] din,
    input logic [DATA_W-1:0] off,
    input logic [DATA_W-1:0] gn,
    input logic [DATA_W-1:0] cd
  );
    logic [31:0] w;
    w = 32'h00000000;
    case (addr)
      mdcc_pkg::CTRL_OFFSET:     w = ctrl;
      mdcc_pkg::SFR_OFFSET:      w = {20'h00000, sfr};
      mdcc_pkg::RDSEL_OFFSET:    w = {26'h0000000, sel};
      mdcc_pkg::RDINPUT_OFFSET:  w = 32'(din);
      mdcc_pkg::RDOFFSET_OFFSET: w = 32'(off);
      mdcc_pkg::RDGAIN_OFFSET:   w = 32'(gn);
      mdcc_pkg::RDCODE_OFFSET:   w = 32'(cd);
      default:                   w = 32'h00000000;
    endcase
    rd_word = w;
  endfunction

  // Bus answer registers
  logic              pready_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;

  // Host-visible registers
  logic              ref_source_r;
  logic              ref_level_r;
  logic [11:0]       sfr_word_r;
  logic [5:0]        rd_sel_r;

  // Load pin history
  logic              load_sync1_r;
  logic              load_sync2_r;
  logic              load_prev_r;

  // Channel storage
  logic [DATA_W-1:0] input_r  [NUM_CH];
  logic [DATA_W-1:0] gain_r   [NUM_CH];
  logic [DATA_W-1:0] offset_r [NUM_CH];
  logic [DATA_W-1:0] code_r   [NUM_CH];

  // Bus phase wires
  logic              take_w;
  logic              commit_w;
  logic              mapped_w;
  logic              hit_ctrl;
  logic              hit_wr;
  logic              hit_load;
  logic              hit_sfr;
  logic              hit_rsel;
  logic              hit_rin;
  logic              hit_roff;
  logic              hit_rgn;
  logic              hit_rcd;

  // Bus phase decode
  assign take_w   = psel_i & penable_i & ~pready_r;
  assign commit_w = psel_i & penable_i & pready_r & pwrite_i;
  assign hit_ctrl = (paddr_i == mdcc_pkg::CTRL_OFFSET);
  assign hit_wr   = (paddr_i == mdcc_pkg::WRITE_OFFSET);
  assign hit_load = (paddr_i == mdcc_pkg::LOAD_OFFSET);
  assign hit_sfr  = (paddr_i == mdcc_pkg::SFR_OFFSET);
  assign hit_rsel = (paddr_i == mdcc_pkg::RDSEL_OFFSET);
  assign hit_rin  = (paddr_i == mdcc_pkg::RDINPUT_OFFSET);
  assign hit_roff = (paddr_i == mdcc_pkg::RDOFFSET_OFFSET);
  assign hit_rgn  = (paddr_i == mdcc_pkg::RDGAIN_OFFSET);
  assign hit_rcd  = (paddr_i == mdcc_pkg::RDCODE_OFFSET);
  assign mapped_w = hit_ctrl | hit_wr | hit_load | hit_sfr | hit_rsel
                  | hit_rin | hit_roff | hit_rgn | hit_rcd;

  // Routed word wires
  logic [11:0]       word_data;
  logic [1:0]        word_sel;
  logic [5:0]        word_chan;
  logic              route_w;
  logic              chan_w;
  logic              wr_input;
  logic              wr_offset;
  logic              wr_gain;
  logic              wr_sfr;

  // Routed word fields
  assign word_data = pwdata_i[mdcc_pkg::DATA_MSB:mdcc_pkg::DATA_LSB];
  assign word_sel  = {pwdata_i[mdcc_pkg::SEL_HIGH_POS],
                      pwdata_i[mdcc_pkg::SEL_LOW_POS]};
  assign word_chan = pwdata_i[mdcc_pkg::CHAN_MSB:mdcc_pkg::CHAN_LSB];
  assign route_w   = commit_w & hit_wr;
  assign chan_w    = route_w & chan_ok(word_chan);
  assign wr_input  = chan_w & (word_sel == mdcc_pkg::SEL_INPUT);
  assign wr_offset = chan_w & (word_sel == mdcc_pkg::SEL_OFFSET);
  assign wr_gain   = chan_w & (word_sel == mdcc_pkg::SEL_GAIN);
  assign wr_sfr    = route_w & (word_sel == mdcc_pkg::SEL_SFR);

  // Load strobe wires
  logic              pin_load;
  logic              load_w;

  // Load strobe from pin falling edge or register write
  assign pin_load  = ~load_sync2_r & load_prev_r;
  assign load_w    = pin_load | (commit_w & hit_load);

  // Readback wires
  logic              rd_ok;
  logic [DATA_W-1:0] rd_input;
  logic [DATA_W-1:0] rd_offset;
  logic [DATA_W-1:0] rd_gain;
  logic [DATA_W-1:0] rd_code;
  logic [31:0]       rd_ctrl;
  logic [31:0]       rd_mux;

  // Readback of the selected channel
  assign rd_ok     = chan_ok(rd_sel_r);
  assign rd_input  = rd_ok ? input_r[rd_sel_r]  : '0;
  assign rd_offset = rd_ok ? offset_r[rd_sel_r] : '0;
  assign rd_gain   = rd_ok ? gain_r[rd_sel_r]   : '0;
  assign rd_code   = rd_ok ? code_r[rd_sel_r]   : '0;
  assign rd_ctrl   = {30'h00000000, ref_level_r, ref_source_r};
  assign rd_mux    = rd_word(paddr_i, rd_ctrl, sfr_word_r, rd_sel_r,
                             rd_input, rd_offset, rd_gain, rd_code);

  // Ready pulse, one wait state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= take_w;
    end
  end

  // Read data, zero outside the answer cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_r <= 32'h00000000;
    end else begin
      prdata_r <= (take_w & ~pwrite_i) ? rd_mux : 32'h00000000;
    end
  end

  // Error flag for unmapped addresses
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= take_w & ~mapped_w;
    end
  end

  // Reference source bit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_source_r <= mdcc_pkg::REF_SOURCE_RESET;
    end else if (commit_w & hit_ctrl) begin
      ref_source_r <= pwdata_i[mdcc_pkg::REF_SOURCE_POS];
    end
  end

  // Reference level bit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_level_r <= mdcc_pkg::REF_LEVEL_RESET;
    end else if (commit_w & hit_ctrl) begin
      ref_level_r <= pwdata_i[mdcc_pkg::REF_LEVEL_POS];
    end
  end

  // Special function word, stored only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_word_r <= 12'h000;
    end else if (wr_sfr) begin
      sfr_word_r <= word_data;
    end
  end

  // Readback channel select
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_sel_r <= 6'h00;
    end else if (commit_w & hit_rsel) begin
      rd_sel_r <= pwdata_i[5:0];
    end
  end

  // Load pin synchroniser and edge history
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_sync1_r <= 1'b1;
      load_sync2_r <= 1'b1;
      load_prev_r  <= 1'b1;
    end else begin
      load_sync1_r <= load_outputs_strobe_n_i;
      load_sync2_r <= load_sync1_r;
      load_prev_r  <= load_sync2_r;
    end
  end

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    logic        sel_ch;
    logic        wr_in_ch;
    logic        wr_off_ch;
    logic        wr_gn_ch;
    logic [12:0] gain_b;
    logic [24:0] prod;
    logic [14:0] sum;
    logic [11:0] corr;

    // Per-channel write strobes
    assign sel_ch    = (word_chan == 6'(ch));
    assign wr_in_ch  = wr_input & sel_ch;
    assign wr_off_ch = wr_offset & sel_ch;
    assign wr_gn_ch  = wr_gain & sel_ch;

    assign gain_b = {1'b0, gain_r[ch]} + mdcc_pkg::GAIN_BIAS;
    assign prod   = gain_b * input_r[ch];
    assign sum    = {2'b00, prod[24:12]} + {3'b000, offset_r[ch]}
                  - mdcc_pkg::OFFSET_MID;
    assign corr   = sum[14]              ? 12'h000 :
                    (sum[13:12] != 2'h0) ? mdcc_pkg::CODE_MAX :
                                           sum[11:0];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        input_r[ch] <= mdcc_pkg::INPUT_RESET;
      end else if (wr_in_ch) begin
        input_r[ch] <= word_data;
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        offset_r[ch] <= mdcc_pkg::OFFSET_RESET;
      end else if (wr_off_ch) begin
        offset_r[ch] <= word_data;
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        gain_r[ch] <= mdcc_pkg::GAIN_RESET;
      end else if (wr_gn_ch) begin
        gain_r[ch] <= {word_data[11:1], 1'b0};
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        code_r[ch] <= mdcc_pkg::CODE_RESET;
      end else if (load_w) begin
        code_r[ch] <= corr;
      end
    end

    // Converter code of this channel
    assign dac_code_o[ch*DATA_W +: DATA_W] = code_r[ch];
  end

  // Bus outputs from flip-flops
  assign prdata_o           = prdata_r;
  assign pready_o           = pready_r;
  assign pslverr_o          = pslverr_r;

  // Reference outputs from flip-flops
  assign reference_source_o = ref_source_r;
  assign reference_level_o  = ref_level_r;

endmodule

// File: mdcc_props.sv
// Checker for bus timing and code loading
module mdcc_props #(
  parameter int NUM_CH = mdcc_pkg::NUM_CHANNELS,
  parameter int DATA_W = mdcc_pkg::CODE_W
) (
  input wire logic                     clk_i,
  input wire logic                     arst_n_i,
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic                     pwrite_i,
  input wire logic [11:0]              paddr_i,
  input wire logic [31:0]              pwdata_i,
  input wire logic [31:0]              prdata_o,
  input wire logic                     pready_o,
  input wire logic                     pslverr_o,
  input wire logic                     load_outputs_strobe_n_i,
  input wire logic                     reference_source_o,
  input wire logic                     reference_level_o,
  input wire logic [NUM_CH*DATA_W-1:0] dac_code_o
);
  wire logic fin = psel_i & penable_i & pready_o;
  wire logic wr  = fin & pwrite_i;
  wire logic ctl = wr & (paddr_i == mdcc_pkg::CTRL_OFFSET);
  wire logic ld  = wr & (paddr_i == mdcc_pkg::LOAD_OFFSET);
  wire logic map = (paddr_i <= 12'h020) && (paddr_i[1:0] == 2'h0);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_wait; psel_i & penable_i & !pready_o |=> pready_o;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_idle; !pready_o |-> prdata_o == 32'h0 && !pslverr_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bus data");
  property p_err; fin |-> pslverr_o == !map; endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_ctrl; ctl |=> reference_source_o == $past(pwdata_i[0])
    && reference_level_o == $past(pwdata_i[1]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl bits");
  property p_ref; $changed(reference_source_o) |-> $past(ctl); endproperty
  a_ref: assert property (p_ref) else $error("ref moved");
  property p_load; $changed(dac_code_o) |-> $past(ld)
    || !$past(load_outputs_strobe_n_i, 2)
    || !$past(load_outputs_strobe_n_i, 3); endproperty
  a_load: assert property (p_load) else $error("code moved");
  property p_gain; fin && !pwrite_i && paddr_i == mdcc_pkg::RDGAIN_OFFSET
    |-> !prdata_o[0]; endproperty
  a_gain: assert property (p_gain) else $error("gain bit 0");
endmodule
bind mdcc_channel_core mdcc_props #(.NUM_CH(NUM_CH), .DATA_W(DATA_W))
  u_props (.*);

// File: mdcc_host.sv
// Bus master model standing for the host processor
module mdcc_host (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [11:0] paddr_o,
  output logic      [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h0;
    pwdata_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule

// File: multichannel_dac_code_calibration_bench.sv
// Self-checking bench of the code path
module multichannel_dac_code_calibration_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic strb_n = 1'b1;
  logic psel, pen, pwr, rdy, err, rs, rl, e;
  logic [11:0] pa, v;
  logic [31:0] pwd, prd, r;
  logic [479:0] dac;
  logic [11:0] xi [40], xg [40], xo [40], snap [40];
  int mismatches = 0;
  int total_checks = 0;
  int seed = 32'h7a5f5113;
  int k;
  always #5 clk_i = ~clk_i;
  mdcc_channel_core DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .load_outputs_strobe_n_i(strb_n), .reference_source_o(rs),
    .reference_level_o(rl), .dac_code_o(dac));
  mdcc_host host (.clk_i(clk_i), .pready_i(rdy), .prdata_i(prd),
    .pslverr_i(err), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(pa), .pwdata_o(pwd));
  function automatic logic [11:0] code_of(int c);
    int s;
    s = ((int'(xg[c]) + 2) * int'(xi[c]) >>> 12) + int'(xo[c]) - 2048;
    return s < 0 ? 12'h000 : (s > 4095 ? 12'hFFF : s[11:0]);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic route(int c, logic [1:0] s, logic [11:0] d);
    wr(mdcc_pkg::WRITE_OFFSET, {10'h0, c[5:0], 2'h0, s, d});
  endtask
  task automatic chk_all;
    @(negedge clk_i);
    for (int c = 0; c < 40; c++)
      chk({20'h0, dac[12*c +: 12]}, {20'h0, snap[c]});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial begin
    for (int c = 0; c < 40; c++) begin
      xi[c] = 12'h000;
      xg[c] = 12'hFFE;
      xo[c] = 12'h800;
      snap[c] = 12'h000;
    end
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wr(mdcc_pkg::RDSEL_OFFSET, 32'h27);
    rd(mdcc_pkg::RDGAIN_OFFSET, 32'hFFE);
    rd(mdcc_pkg::RDOFFSET_OFFSET, 32'h800);
    rd(mdcc_pkg::CTRL_OFFSET, 32'h0);
    chk_all();
    for (int n = 0; n < 4; n++) begin
      wr(mdcc_pkg::CTRL_OFFSET, 32'(n));
      @(negedge clk_i);
      chk({30'h0, rl, rs}, 32'(n));
    end
    $display("test reset_and_reference done");
    for (int n = 0; n < 12; n++) begin
      k = n < 5 ? 39 - n : $unsigned($random(seed)) % 40;
      xi[k] = n < 5 ? 12'hFFF : 12'($random(seed));
      xo[k] = n < 2 ? {12{n[0]}} : 12'($random(seed));
      v = n < 5 ? 12'hFFE >> n : 12'($random(seed));
      xg[k] = v & 12'hFFE;
      route(k, mdcc_pkg::SEL_INPUT, xi[k]);
      route(k, mdcc_pkg::SEL_OFFSET, xo[k]);
      route(k, mdcc_pkg::SEL_GAIN, v | 12'h001);
      wr(mdcc_pkg::RDSEL_OFFSET, 32'(k));
      rd(mdcc_pkg::RDGAIN_OFFSET, {20'h0, xg[k]});
      rd(mdcc_pkg::RDINPUT_OFFSET, {20'h0, xi[k]});
      chk_all();
      if (n[0]) begin
        strb_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        strb_n <= 1'b1;
      end else begin
        wr(mdcc_pkg::LOAD_OFFSET, 32'h0);
      end
      for (int c = 0; c < 40; c++)
        snap[c] = code_of(c);
      chk_all();
      rd(mdcc_pkg::RDCODE_OFFSET, {20'h0, snap[k]});
    end
    $display("test coefficients done");
    route(0, mdcc_pkg::SEL_SFR, 12'hA5C);
    rd(mdcc_pkg::SFR_OFFSET, 32'hA5C);
    route(40, mdcc_pkg::SEL_INPUT, 12'hFFF);
    wr(mdcc_pkg::LOAD_OFFSET, 32'h0);
    chk_all();
    host.xfer(1'b0, 12'h024, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    $display("test routing_edges done");
    complete_run();
  end
endmodule
